// file: logic/conv_sched_pkg.sv
// Package: constants and carriers for the conversion scheduler
package conv_sched_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CONV_TIME_MS    = 125;
    localparam int unsigned CONV_CYCLES     = CONV_TIME_MS * (CLK_HZ / 1000);
    // Base interval of the slowest rate code (16 s), in ms
    localparam int unsigned BASE_PERIOD_MS  = 16000;
    localparam int unsigned BASE_PERIOD_CYC = BASE_PERIOD_MS * (CLK_HZ / 1000);

    // Register reset values
    localparam logic [7:0] RATE_RST         = 8'h02;
    localparam logic [7:0] CMD_PTR_RST      = 8'h00;
    localparam logic [7:0] THIGH_RST        = 8'h7f;
    localparam logic [7:0] TLOW_RST         = 8'h80;
    localparam logic [7:0] CONFIG_RST       = 8'h00;

    // Field positions
    localparam int unsigned RATE_CODE_W     = 3;
    localparam int unsigned CFG_MASK_BIT    = 7;
    localparam int unsigned CFG_HALT_BIT    = 6;

    // SMBus alert response address
    localparam logic [6:0] ALERT_RESP_ADDR  = 7'h0c;

    // Three-state strap levels
    typedef enum logic [1:0] {
        STRAP_LOW,
        STRAP_OPEN,
        STRAP_HIGH
    } strap_level_e;

    // Address bases for first strap low, open, high
    localparam logic [6:0] ADDR_BASE_LOW    = 7'h18;
    localparam logic [6:0] ADDR_BASE_OPEN   = 7'h29;
    localparam logic [6:0] ADDR_BASE_HIGH   = 7'h4c;

    // Register writes arriving from the serial front end
    typedef struct packed {
        logic       rate_wr;
        logic       cfg_wr;
        logic       thigh_wr;
        logic       tlow_wr;
        logic       ptr_wr;
        logic       one_shot;
        logic [7:0] data;
    } reg_write_s;

    // Results and state shown to the front end
    typedef struct packed {
        logic [7:0] local_t;
        logic [7:0] remote_t;
        logic       busy;
    } result_s;

endpackage : conv_sched_pkg

// file: logic/strap_decode.sv
// Decoder from two three-state straps to the 7-bit slave address
`timescale 1ns/1ps
module strap_decode
    import conv_sched_pkg::*;
(
    input  wire logic [1:0] strap_a_in,
    input  wire logic [1:0] strap_b_in,
    output logic      [6:0] addr_out
);

    logic [6:0] base;
    logic [6:0] step;

    always_comb
    begin
        case (strap_a_in)
            STRAP_LOW:  base = ADDR_BASE_LOW;
            STRAP_OPEN: base = ADDR_BASE_OPEN;
            default:    base = ADDR_BASE_HIGH;
        endcase
        case (strap_b_in)
            STRAP_LOW:  step = 7'h00;
            STRAP_OPEN: step = 7'h01;
            default:    step = 7'h02;
        endcase
        addr_out = base + step;
    end

endmodule : strap_decode

// file: logic/conversion_scheduler.sv
// Conversion scheduler, power-up defaults and strap address latch
`timescale 1ns/1ps
module conversion_scheduler
    import conv_sched_pkg::*;
#(
    parameter int unsigned CONV_CYC = CONV_CYCLES,
    parameter int unsigned BASE_CYC = BASE_PERIOD_CYC
)
(
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic [1:0] addr_strap_a_in,
    input  wire logic [1:0] addr_strap_b_in,
    input  wire logic       hw_standby_pin_in,
    input  wire logic       supply_lockout_in,
    input  reg_write_s      wr_in,
    input  wire logic [7:0] adc_local_in,
    input  wire logic [7:0] adc_remote_in,
    input  wire logic       alert_set_in,
    input  wire logic       alert_clr_in,
    input  wire logic       link_clk_in,
    output result_s         result_out,
    output logic      [7:0] conversion_rate_select_out,
    output logic      [7:0] config_out,
    output logic      [7:0] cmd_ptr_out,
    output logic      [7:0] thigh_out,
    output logic      [7:0] tlow_out,
    output logic      [6:0] slave_addr_out,
    output logic      [6:0] alert_addr_out,
    output logic            alert_latch_out,
    output logic            link_edge_out
);

    // Refuse timings that the counters cannot serve
    if (CONV_CYC < 1 || BASE_CYC < 16 || (BASE_CYC % 128) != 0 || CONV_CYC >= BASE_CYC)
    begin : g_bad_timing
        $error("conversion_scheduler: bad timing parameters");
    end

    localparam int unsigned CNT_W = $clog2(BASE_CYC + 1);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV
    } conv_state_e;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] standby_sync_r, lock_sync_r, lclk_sync_r;
    logic [1:0] sa_meta_r, sa_sync_r, sb_meta_r, sb_sync_r;
    logic       lclk_prev_r;
    logic       standby, locked;

    always_ff @(posedge ref_clk_in)
    begin
        standby_sync_r <= {standby_sync_r[0], hw_standby_pin_in};
        lock_sync_r <= {lock_sync_r[0], supply_lockout_in};
        lclk_sync_r <= {lclk_sync_r[0], link_clk_in};
        lclk_prev_r <= lclk_sync_r[1];
        sa_meta_r   <= addr_strap_a_in;
        sa_sync_r   <= sa_meta_r;
        sb_meta_r   <= addr_strap_b_in;
        sb_sync_r   <= sb_meta_r;
    end

    assign standby = standby_sync_r[1];
    assign locked  = lock_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Strap address latch
    logic [6:0] dec_addr;
    logic [1:0] strap_wait_r, strap_wait_nxt;
    logic [6:0] addr_r, addr_nxt;

    strap_decode u_strap_decode (
        .strap_a_in (sa_sync_r),
        .strap_b_in (sb_sync_r),
        .addr_out   (dec_addr)
    );

    always_comb
    begin
        strap_wait_nxt = strap_wait_r;
        addr_nxt       = addr_r;
        if (strap_wait_r != 2'h3)
        begin
            strap_wait_nxt = strap_wait_r + 2'h1;
            addr_nxt       = dec_addr;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            strap_wait_r <= 2'h0;
            addr_r       <= 7'h00;
        end
        else
        begin
            strap_wait_r <= strap_wait_nxt;
            addr_r       <= addr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] rate_r, rate_nxt, cfg_r, cfg_nxt, ptr_r, ptr_nxt;
    logic [7:0] thigh_r, thigh_nxt, tlow_r, tlow_nxt;
    logic       alert_r, alert_nxt;

    always_comb
    begin
        rate_nxt  = rate_r;
        cfg_nxt   = cfg_r;
        ptr_nxt   = ptr_r;
        thigh_nxt = thigh_r;
        tlow_nxt  = tlow_r;
        alert_nxt = alert_r;
        if (wr_in.rate_wr)
            rate_nxt = wr_in.data;
        if (wr_in.cfg_wr)
            cfg_nxt = {wr_in.data[7:6], 6'h00};
        if (wr_in.ptr_wr)
            ptr_nxt = wr_in.data;
        if (wr_in.thigh_wr)
            thigh_nxt = wr_in.data;
        if (wr_in.tlow_wr)
            tlow_nxt = wr_in.data;
        if (alert_clr_in)
            alert_nxt = 1'b0;
        if (alert_set_in && !cfg_r[CFG_MASK_BIT])
            alert_nxt = 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            rate_r  <= RATE_RST;
            cfg_r   <= CONFIG_RST;
            ptr_r   <= CMD_PTR_RST;
            thigh_r <= THIGH_RST;
            tlow_r  <= TLOW_RST;
            alert_r <= 1'b0;
        end
        else
        begin
            rate_r  <= rate_nxt;
            cfg_r   <= cfg_nxt;
            ptr_r   <= ptr_nxt;
            thigh_r <= thigh_nxt;
            tlow_r  <= tlow_nxt;
            alert_r <= alert_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion scheduler
    conv_state_e     state_r, state_nxt;
    logic [CNT_W-1:0] conv_cnt_r, conv_cnt_nxt, rate_cnt_r, rate_cnt_nxt;
    logic [CNT_W-1:0] interval;
    logic [2:0]      code;
    logic            halted, auto_mode, start;
    logic [7:0]      loc_r, loc_nxt, rem_r, rem_nxt;
    logic            standby_prev_r, halt_prev_r, wake;

    assign code      = rate_r[RATE_CODE_W-1:0];
    assign interval  = CNT_W'(BASE_CYC >> code);
    assign halted    = cfg_r[CFG_HALT_BIT] || standby;
    assign auto_mode = !halted;
    assign wake      = (standby_prev_r && !standby) || (halt_prev_r && !cfg_r[CFG_HALT_BIT]);

    always_comb
    begin
        state_nxt    = state_r;
        conv_cnt_nxt = conv_cnt_r;
        rate_cnt_nxt = rate_cnt_r;
        loc_nxt      = loc_r;
        rem_nxt      = rem_r;
        start        = 1'b0;
        if (wr_in.rate_wr)
            rate_cnt_nxt = '0;
        else if (auto_mode && rate_cnt_r < interval - CNT_W'(1))
            rate_cnt_nxt = rate_cnt_r + CNT_W'(1);
        case (state_r)
            ST_IDLE:
            begin
                if (!locked)
                begin
                    // Leaving one standby starts nothing while the other still holds
                    if (wr_in.one_shot || (wake && !halted))
                        start = 1'b1;
                    else if (auto_mode && !wr_in.rate_wr && rate_cnt_r >= interval - CNT_W'(1))
                        start = 1'b1;
                end
                if (start)
                begin
                    state_nxt    = ST_CONV;
                    conv_cnt_nxt = '0;
                    rate_cnt_nxt = '0;
                end
            end
            ST_CONV:
            begin
                // One-shot ignored here
                // Standby pin or a freshly set halt bit abandons the conversion
                if (standby || (cfg_r[CFG_HALT_BIT] && !halt_prev_r))
                    state_nxt = ST_IDLE;
                else if (conv_cnt_r >= CNT_W'(CONV_CYC - 1))
                begin
                    state_nxt = ST_IDLE;
                    loc_nxt   = adc_local_in;
                    rem_nxt   = adc_remote_in;
                end
                else
                    conv_cnt_nxt = conv_cnt_r + CNT_W'(1);
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state_r     <= ST_IDLE;
            conv_cnt_r  <= '0;
            rate_cnt_r  <= '1 >> 1;
            loc_r       <= 8'h00;
            rem_r       <= 8'h00;
            standby_prev_r <= 1'b0;
            halt_prev_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            conv_cnt_r  <= conv_cnt_nxt;
            rate_cnt_r  <= (rate_cnt_nxt > interval) ? interval : rate_cnt_nxt;
            loc_r       <= loc_nxt;
            rem_r       <= rem_nxt;
            standby_prev_r <= standby;
            halt_prev_r <= cfg_r[CFG_HALT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            result_out                 <= '0;
            conversion_rate_select_out <= RATE_RST;
            config_out                 <= CONFIG_RST;
            cmd_ptr_out                <= CMD_PTR_RST;
            thigh_out                  <= THIGH_RST;
            tlow_out                   <= TLOW_RST;
            slave_addr_out             <= 7'h00;
            alert_addr_out             <= ALERT_RESP_ADDR;
            alert_latch_out            <= 1'b0;
            link_edge_out              <= 1'b0;
        end
        else
        begin
            result_out                 <= '{local_t: loc_r, remote_t: rem_r, busy: state_r == ST_CONV};
            conversion_rate_select_out <= rate_r;
            config_out                 <= cfg_r;
            cmd_ptr_out                <= ptr_r;
            thigh_out                  <= thigh_r;
            tlow_out                   <= tlow_r;
            slave_addr_out             <= addr_r;
            alert_addr_out             <= ALERT_RESP_ADDR;
            alert_latch_out            <= alert_r;
            link_edge_out              <= lclk_sync_r[1] && !lclk_prev_r;
        end
    end

endmodule : conversion_scheduler

// file: testbench/conv_sched_checker.sv
// Port checks for the conversion scheduler
`timescale 1ns/1ps
module conv_sched_checker
    import conv_sched_pkg::*;
(
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    input wire logic [1:0] addr_strap_a_in,
    input wire logic [1:0] addr_strap_b_in,
    input wire logic       hw_standby_pin_in,
    input wire logic       supply_lockout_in,
    input reg_write_s      wr_in,
    input result_s         result_out,
    input wire logic [7:0] conversion_rate_select_out,
    input wire logic [7:0] config_out,
    input wire logic [7:0] cmd_ptr_out,
    input wire logic [7:0] thigh_out,
    input wire logic [7:0] tlow_out,
    input wire logic [6:0] slave_addr_out,
    input wire logic [6:0] alert_addr_out,
    input wire logic       alert_latch_out
);
    localparam int CONV_LIM = 14;
    logic [3:0] cnt_r, cnt_nxt;
    logic [1:0] sa_r, sa_nxt, sb_r, sb_nxt;
    logic [6:0] exp_addr;

    // Straps seen during reset give the expected address
    always_comb
    begin
        cnt_nxt = rst_in ? 4'h0 : (cnt_r == 4'hf ? cnt_r : cnt_r + 4'h1);
        sa_nxt = rst_in ? addr_strap_a_in : sa_r;
        sb_nxt = rst_in ? addr_strap_b_in : sb_r;
        exp_addr = (sa_r == 2'h0 ? 7'h18 : sa_r == 2'h1 ? 7'h29 : 7'h4c) + (sb_r == 2'h3 ? 7'h2 : {5'h0, sb_r});
    end

    always_ff @(posedge ref_clk_in)
    begin
        cnt_r <= cnt_nxt;
        sa_r <= sa_nxt;
        sb_r <= sb_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_fire;
        (!supply_lockout_in && !hw_standby_pin_in)[*4] ##0 wr_in.one_shot;
    endsequence
    sequence s_conv;
        result_out.busy[*7] ##[1:CONV_LIM] !result_out.busy;
    endsequence

    a_reset_defaults: assert property (
        $fell(rst_in) |-> {conversion_rate_select_out, config_out, cmd_ptr_out, thigh_out, tlow_out,
        alert_latch_out} == {40'h0200007f80, 1'b0})
        else $error("reset defaults wrong");
    a_rate_store: assert property (
        wr_in.rate_wr |-> ##2 conversion_rate_select_out == $past(wr_in.data, 2))
        else $error("rate write lost");
    a_addr_latched: assert property (
        cnt_r > 4'h8 |-> slave_addr_out == exp_addr && alert_addr_out == 7'h0c)
        else $error("slave address wrong");
    a_oneshot_starts: assert property (
        s_fire |-> ##[1:3] result_out.busy)
        else $error("one-shot did not start");
    a_conv_length: assert property (
        $rose(result_out.busy) |-> s_conv)
        else $error("conversion length wrong");
    a_pair_update: assert property (
        $changed(result_out.local_t) || $changed(result_out.remote_t) |-> ##[0:1] !result_out.busy)
        else $error("results changed mid conversion");
    a_lockout_holds: assert property (
        supply_lockout_in[*6] |-> !$rose(result_out.busy))
        else $error("conversion under lockout");
    a_halt_holds: assert property (
        (config_out[6] && !wr_in.one_shot)[*4] |-> !$rose(result_out.busy))
        else $error("conversion while halted");
endmodule : conv_sched_checker

bind conversion_scheduler conv_sched_checker u_chk (
    .ref_clk_in                 (ref_clk_in),
    .rst_in                     (rst_in),
    .addr_strap_a_in            (addr_strap_a_in),
    .addr_strap_b_in            (addr_strap_b_in),
    .hw_standby_pin_in          (hw_standby_pin_in),
    .supply_lockout_in          (supply_lockout_in),
    .wr_in                      (wr_in),
    .result_out                 (result_out),
    .conversion_rate_select_out (conversion_rate_select_out),
    .config_out                 (config_out),
    .cmd_ptr_out                (cmd_ptr_out),
    .thigh_out                  (thigh_out),
    .tlow_out                   (tlow_out),
    .slave_addr_out             (slave_addr_out),
    .alert_addr_out             (alert_addr_out),
    .alert_latch_out            (alert_latch_out)
);

// file: testbench/host_model.sv
// Host controller model: framed register writes
`timescale 1ns/1ps
module host_model
    import conv_sched_pkg::*;
(
    input  wire logic ref_clk_in,
    output reg_write_s wr_out,
    output logic       link_clk_out
);
    initial
    begin
        wr_out = '0;
        link_clk_out = 1'b0;
    end

    // Link clock idles low outside frames
    task automatic send(input logic [5:0] sel, input logic [7:0] data, input int clocks);
        repeat (clocks)
        begin
            #160 link_clk_out = 1'b1;
            #160 link_clk_out = 1'b0;
        end
        @(posedge ref_clk_in);
        #1 wr_out = {sel, data};
        @(posedge ref_clk_in);
        #1 wr_out = '0;
    endtask : send
endmodule : host_model

// file: testbench/conversion_scheduler_bench.sv
// Self-checking bench for the conversion scheduler
`timescale 1ns/1ps
module conversion_scheduler_addr_por_bench
    import conv_sched_pkg::*;
();
    localparam int CC = 10;
    localparam int BC = 1280;
    logic       ref_clk_in, rst_in, hw_standby_pin_in, supply_lockout_in, link_clk_in;
    logic       alert_set_in, alert_clr_in, alert_latch_out, link_edge_out;
    logic [1:0] addr_strap_a_in, addr_strap_b_in;
    logic [7:0] adc_local_in, adc_remote_in, conversion_rate_select_out, config_out;
    logic [7:0] cmd_ptr_out, thigh_out, tlow_out;
    logic [6:0] slave_addr_out, alert_addr_out;
    reg_write_s wr_in;
    result_s    result_out;
    int         mismatches, checked, cyc, edges, n, e0;

    conversion_scheduler #(.CONV_CYC(CC), .BASE_CYC(BC)) dut (
        .ref_clk_in                 (ref_clk_in),
        .rst_in                     (rst_in),
        .addr_strap_a_in            (addr_strap_a_in),
        .addr_strap_b_in            (addr_strap_b_in),
        .hw_standby_pin_in          (hw_standby_pin_in),
        .supply_lockout_in          (supply_lockout_in),
        .wr_in                      (wr_in),
        .adc_local_in               (adc_local_in),
        .adc_remote_in              (adc_remote_in),
        .alert_set_in               (alert_set_in),
        .alert_clr_in               (alert_clr_in),
        .link_clk_in                (link_clk_in),
        .result_out                 (result_out),
        .conversion_rate_select_out (conversion_rate_select_out),
        .config_out                 (config_out),
        .cmd_ptr_out                (cmd_ptr_out),
        .thigh_out                  (thigh_out),
        .tlow_out                   (tlow_out),
        .slave_addr_out             (slave_addr_out),
        .alert_addr_out             (alert_addr_out),
        .alert_latch_out            (alert_latch_out),
        .link_edge_out              (link_edge_out)
    );
    host_model hm (.ref_clk_in(ref_clk_in), .wr_out(wr_in), .link_clk_out(link_clk_in));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in)
    begin
        cyc++;
        edges += int'(link_edge_out === 1'b1);
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Drain a running conversion, then wait for the next one
    task automatic gap(input int lim, output int k);
        for (k = 0; result_out.busy === 1'b1 && k < lim; k++)
            tick(1);
        for (; result_out.busy !== 1'b1 && k < lim; k++)
            tick(1);
    endtask : gap

    task automatic conv(input int lim);
        int d;
        gap(lim, n);
        chk(n < lim, 1'b1);
        for (d = 0; result_out.busy === 1'b1 && d < 30; d++)
            tick(1);
        tick(1);
        chk(d >= CC - 3 && d <= CC + 2, 1'b1);
        chk({result_out.local_t, result_out.remote_t}, {adc_local_in, adc_remote_in});
    endtask : conv

    task automatic quiet(input int lim);
        gap(lim, n);
        chk(n, lim);
    endtask : quiet

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_in = 1'b1;
        {hw_standby_pin_in, supply_lockout_in, alert_set_in, alert_clr_in} = 4'h0;
        {addr_strap_a_in, addr_strap_b_in} = 4'h5;
        {adc_local_in, adc_remote_in} = 16'h19e7;
        tick(6);
        rst_in = 1'b0;
        tick(6);
        chk({conversion_rate_select_out, config_out, thigh_out, tlow_out}, 32'h02007f80);
        chk({cmd_ptr_out, alert_latch_out, slave_addr_out, 1'b0, alert_addr_out}, 24'h002a0c);
        conv(500);
        $display("power-up test done");
        {adc_local_in, adc_remote_in} = 16'h2c91;
        e0 = edges;
        hm.send(6'h01, 8'h00, 4);
        conv(4);
        chk(edges - e0, 4);
        gap(500, n);
        chk(n >= 200 && n <= 420, 1'b1);
        hm.send(6'h01, 8'h00, 0);
        quiet(200);
        $display("one-shot test done");
        for (int c = 0; c < 8; c++)
        begin
            hm.send(6'h20, {c[0] ? 5'h15 : 5'h00, c[2:0]}, 4);
            tick(2);
            chk(conversion_rate_select_out, {c[0] ? 5'h15 : 5'h00, c[2:0]});
            gap(BC * 2, n);
            chk(n + 3 >= (BC >> c) * 3 / 4 && n <= (BC >> c) * 5 / 4, 1'b1);
            gap(BC * 2, n);
            chk(n >= (BC >> c) * 3 / 4 && n <= (BC >> c) * 5 / 4 + 1, 1'b1);
        end
        hm.send(6'h20, 8'h02, 4);
        $display("rate test done");
        hm.send(6'h10, 8'h40, 4);
        tick(2);
        chk(config_out, 8'h40);
        quiet(700);
        adc_local_in = 8'h05;
        hm.send(6'h01, 8'h00, 0);
        conv(4);
        quiet(700);
        hm.send(6'h10, 8'h00, 4);
        conv(8);
        hw_standby_pin_in = 1'b1;
        quiet(700);
        hw_standby_pin_in = 1'b0;
        conv(10);
        supply_lockout_in = 1'b1;
        tick(4);
        hm.send(6'h01, 8'h00, 0);
        quiet(700);
        supply_lockout_in = 1'b0;
        conv(500);
        $display("standby test done");
        hm.send(6'h08, 8'h55, 4);
        hm.send(6'h04, 8'h66, 4);
        hm.send(6'h02, 8'h01, 4);
        {alert_set_in, alert_clr_in} = 2'h3;
        tick(1);
        {alert_set_in, alert_clr_in} = 2'h0;
        {addr_strap_a_in, addr_strap_b_in} = 4'hb;
        tick(8);
        chk({thigh_out, tlow_out, cmd_ptr_out, alert_latch_out, slave_addr_out}, 32'h556601aa);
        for (int i = 0; i < 9; i++)
        begin
            {alert_set_in, addr_strap_a_in, addr_strap_b_in} = {1'b0, 2'(i / 3), 2'(i % 3)};
            rst_in = 1'b1;
            tick(6);
            rst_in = 1'b0;
            tick(6);
            chk({thigh_out, tlow_out, cmd_ptr_out, alert_latch_out, slave_addr_out},
                {24'h7f8000, 1'b0, (i < 3 ? 7'h18 : i < 6 ? 7'h29 : 7'h4c) + 7'(i % 3)});
        end
        $display("address test done");
        wrap_up();
    end
endmodule : conversion_scheduler_addr_por_bench
